/* hw/pvr_pkg.sv */
package pvr_pkg;

    // -------------------------------------------------------------------------
    // register indexes on the management bus
    // -------------------------------------------------------------------------
    localparam logic [4:0] PVR_IDX_MMD_CTRL = 5'h0d;
    localparam logic [4:0] PVR_IDX_MMD_DATA = 5'h0e;
    localparam logic [4:0] PVR_IDX_XOVER = 5'h1c;
    localparam logic [4:0] PVR_IDX_PWRDN = 5'h1d;
    localparam logic [4:0] PVR_IDX_LOOPBACK = 5'h1e;
    localparam logic [4:0] PVR_IDX_CTRL_STAT = 5'h1f;

    // -------------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------------
    localparam int PVR_XO_PINOUT_BIT = 7;
    localparam int PVR_XO_AUTO_OFF_BIT = 6;
    localparam int PVR_PD_CLK_OVR_BIT = 11;
    localparam int PVR_PD_PLL_OFF_BIT = 10;
    localparam int PVR_PD_DC_TEST_BIT = 7;
    localparam int PVR_PD_TEST_LVL_BIT = 6;
    localparam int PVR_LB_EXT_BIT = 3;
    localparam int PVR_CS_INT_INV_BIT = 14;
    localparam int PVR_CS_JABBER_BIT = 9;
    localparam int PVR_CS_SQE_BIT = 8;
    localparam int PVR_CS_SPD1000_BIT = 6;
    localparam int PVR_CS_SPD100_BIT = 5;
    localparam int PVR_CS_SPD10_BIT = 4;
    localparam int PVR_CS_DUPLEX_BIT = 3;
    localparam int PVR_CS_MASTER_BIT = 2;
    localparam int PVR_CS_SOFT_RST_BIT = 1;
    localparam int PVR_CS_LINK_FAIL_BIT = 0;
    localparam int PVR_MC_FUNC_HI = 15;
    localparam int PVR_MC_FUNC_LO = 14;

    // -------------------------------------------------------------------------
    // values after reset
    // -------------------------------------------------------------------------
    localparam logic PVR_RST_AUTO_OFF = 1'b0;
    localparam logic PVR_RST_JABBER_EN = 1'b1;
    localparam logic PVR_RST_SQE_EN = 1'b1;

    // -------------------------------------------------------------------------
    // management frame
    // -------------------------------------------------------------------------
    localparam logic [5:0] PVR_PREAMBLE_BITS = 6'd32;
    localparam logic [3:0] PVR_HDR_LAST = 4'd12;
    localparam logic [3:0] PVR_DATA_LAST = 4'd15;
    localparam logic [1:0] PVR_OP_READ = 2'b10;
    localparam logic [1:0] PVR_OP_WRITE = 2'b01;

    typedef enum logic [1:0] {
        PVR_MMD_ADDR = 2'b00,
        PVR_MMD_DATA = 2'b01,
        PVR_MMD_INC_RW = 2'b10,
        PVR_MMD_INC_WR = 2'b11
    } pvr_mmd_func_e;

    typedef enum logic [1:0] {
        PVR_FR_PRE = 2'b00,
        PVR_FR_HDR = 2'b01,
        PVR_FR_TA = 2'b11,
        PVR_FR_DAT = 2'b10
    } pvr_frame_e;

endpackage

/* hw/pvr_mdio_engine.sv */
`timescale 1ns/100ps
module pvr_mdio_engine
    import pvr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // register side
    output logic rd_req,
    output logic wr_req,
    output logic [4:0] reg_addr,
    output logic [15:0] wr_data,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data
);

    pvr_frame_e state_ff;
    logic mdc_prev_ff;
    logic [5:0] ones_ff;
    logic [3:0] cnt_ff;
    logic [11:0] hdr_ff;
    logic [15:0] sh_ff;
    logic is_rd_ff;
    logic [12:0] full_hdr;
    logic rise;
    logic fall;
    logic hdr_ok;

    assign rise = mdc & ~mdc_prev_ff;
    assign fall = ~mdc & mdc_prev_ff;
    assign full_hdr = {hdr_ff, mdio_in};
    assign hdr_ok = full_hdr[12] && (full_hdr[9:5] == PHY_ADDR)
                    && (full_hdr[11:10] == PVR_OP_READ || full_hdr[11:10] == PVR_OP_WRITE);

    // -------------------------------------------------------------------------
    // frame sequencing, sampled on mdc rising edge
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mdc_prev_ff <= 1'b0;
            state_ff <= PVR_FR_PRE;
            ones_ff <= 6'd0;
            cnt_ff <= 4'd0;
            hdr_ff <= 12'h000;
            is_rd_ff <= 1'b0;
            rd_req <= 1'b0;
            wr_req <= 1'b0;
            reg_addr <= 5'h00;
            wr_data <= 16'h0000;
        end
        else
        begin
            mdc_prev_ff <= mdc;
            rd_req <= 1'b0;
            wr_req <= 1'b0;
            if (rise)
            begin
                case (state_ff)
                    PVR_FR_PRE:
                    begin
                        if (mdio_in)
                        begin
                            if (ones_ff != PVR_PREAMBLE_BITS)
                                ones_ff <= ones_ff + 6'd1;
                        end
                        else if (ones_ff == PVR_PREAMBLE_BITS)
                        begin
                            state_ff <= PVR_FR_HDR;
                            cnt_ff <= 4'd0;
                            ones_ff <= 6'd0;
                        end
                        else
                            ones_ff <= 6'd0;
                    end
                    PVR_FR_HDR:
                    begin
                        hdr_ff <= full_hdr[11:0];
                        cnt_ff <= cnt_ff + 4'd1;
                        if (cnt_ff == PVR_HDR_LAST)
                        begin
                            cnt_ff <= 4'd0;
                            is_rd_ff <= (full_hdr[11:10] == PVR_OP_READ);
                            reg_addr <= full_hdr[4:0];
                            // frames for another station are dropped here
                            state_ff <= hdr_ok ? PVR_FR_TA : PVR_FR_PRE;
                            rd_req <= hdr_ok && (full_hdr[11:10] == PVR_OP_READ);
                        end
                    end
                    PVR_FR_TA:
                    begin
                        cnt_ff <= cnt_ff + 4'd1;
                        if (cnt_ff == 4'd1)
                        begin
                            cnt_ff <= 4'd0;
                            state_ff <= PVR_FR_DAT;
                        end
                    end
                    PVR_FR_DAT:
                    begin
                        wr_data <= {wr_data[14:0], mdio_in};
                        cnt_ff <= cnt_ff + 4'd1;
                        if (cnt_ff == PVR_DATA_LAST)
                        begin
                            state_ff <= PVR_FR_PRE;
                            wr_req <= ~is_rd_ff;
                        end
                    end
                    default:
                        state_ff <= PVR_FR_PRE;
                endcase
            end
        end
    end

    // -------------------------------------------------------------------------
    // read data drive, changed on mdc falling edge
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_ff <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end
        else
        begin
            if (rd_valid)
                sh_ff <= rd_data;
            if (state_ff != PVR_FR_DAT && state_ff != PVR_FR_TA)
                mdio_oe <= 1'b0;
            else if (fall && is_rd_ff)
            begin
                if (state_ff == PVR_FR_TA && cnt_ff == 4'd1)
                begin
                    mdio_oe <= 1'b1;
                    mdio_out <= 1'b0;
                end
                else if (state_ff == PVR_FR_DAT)
                begin
                    mdio_out <= sh_ff[15];
                    sh_ff <= {sh_ff[14:0], 1'b0};
                end
            end
        end
    end

endmodule

/* hw/pvr_phy_vendor_regs.sv */
`timescale 1ns/100ps
module pvr_phy_vendor_regs
    import pvr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01,
    parameter int EXT_DEV_BITS = 2,
    parameter int EXT_REG_BITS = 4
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // resolved link state
    input wire logic link_speed_1000,
    input wire logic link_speed_100,
    input wire logic link_speed_10,
    input wire logic link_full_duplex,
    input wire logic link_master,
    input wire logic link_check_fail,
    // controls to the phy
    output logic forced_pinout_select,
    output logic auto_crossover_off,
    output logic spd_clock_gate_override,
    output logic spd_pll_disable,
    output logic pin_dc_test_enable,
    output logic pin_test_level,
    output logic ext_loopback_enable,
    output logic int_polarity_invert,
    output logic jabber_enable,
    output logic sqe_test_enable,
    output logic phy_soft_reset
);

    localparam int EXT_WORDS = 1 << (EXT_DEV_BITS + EXT_REG_BITS);

    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic rd_req;
    logic wr_req;
    logic [4:0] reg_addr;
    logic [15:0] wr_data;
    logic rd_valid_ff;
    logic [15:0] rd_data_ff;
    logic [15:0] nxt_rd_data;
    logic pinout_ff;
    logic auto_off_ff;
    logic clk_ovr_ff;
    logic pll_off_ff;
    logic dc_test_ff;
    logic test_lvl_ff;
    logic ext_lb_ff;
    logic int_inv_ff;
    logic jabber_ff;
    logic sqe_ff;
    logic soft_rst_ff;
    logic link_fail_ff;
    pvr_mmd_func_e mmd_func_ff;
    logic [4:0] mmd_dev_ff;
    logic [15:0] mmd_addr_ff;
    logic [15:0] ext_mem [0:EXT_WORDS-1];
    logic wr_hit_data;
    logic rd_hit_data;
    logic mmd_inc;

    function automatic logic [EXT_DEV_BITS+EXT_REG_BITS-1:0] ext_index(
        input logic [4:0] dev,
        input logic [15:0] addr
    );
        ext_index = {dev[EXT_DEV_BITS-1:0], addr[EXT_REG_BITS-1:0]};
    endfunction

    // -------------------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync_ff <= 2'b00;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    // -------------------------------------------------------------------------
    // serial frame engine
    // -------------------------------------------------------------------------
    pvr_mdio_engine #(
        .PHY_ADDR(PHY_ADDR)
    ) u_engine (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .mdc(mdc),
        .mdio_in(mdio_in),
        .mdio_out(mdio_out),
        .mdio_oe(mdio_oe),
        .rd_req(rd_req),
        .wr_req(wr_req),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .rd_valid(rd_valid_ff),
        .rd_data(rd_data_ff)
    );

    assign wr_hit_data = wr_req && reg_addr == PVR_IDX_MMD_DATA;
    assign rd_hit_data = rd_req && reg_addr == PVR_IDX_MMD_DATA;
    // function 3 increments on writes only
    assign mmd_inc = (wr_hit_data && (mmd_func_ff == PVR_MMD_INC_RW
                                      || mmd_func_ff == PVR_MMD_INC_WR))
                     || (rd_hit_data && mmd_func_ff == PVR_MMD_INC_RW);

    // -------------------------------------------------------------------------
    // vendor control registers
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinout_ff <= 1'b0;
            auto_off_ff <= PVR_RST_AUTO_OFF;
            clk_ovr_ff <= 1'b0;
            pll_off_ff <= 1'b0;
            dc_test_ff <= 1'b0;
            test_lvl_ff <= 1'b0;
            ext_lb_ff <= 1'b0;
            int_inv_ff <= 1'b0;
            jabber_ff <= PVR_RST_JABBER_EN;
            sqe_ff <= PVR_RST_SQE_EN;
        end
        else if (wr_req)
        begin
            case (reg_addr)
                PVR_IDX_XOVER:
                begin
                    pinout_ff <= wr_data[PVR_XO_PINOUT_BIT];
                    auto_off_ff <= wr_data[PVR_XO_AUTO_OFF_BIT];
                end
                PVR_IDX_PWRDN:
                begin
                    clk_ovr_ff <= wr_data[PVR_PD_CLK_OVR_BIT];
                    pll_off_ff <= wr_data[PVR_PD_PLL_OFF_BIT];
                    dc_test_ff <= wr_data[PVR_PD_DC_TEST_BIT];
                    test_lvl_ff <= wr_data[PVR_PD_TEST_LVL_BIT];
                end
                PVR_IDX_LOOPBACK:
                    ext_lb_ff <= wr_data[PVR_LB_EXT_BIT];
                PVR_IDX_CTRL_STAT:
                begin
                    int_inv_ff <= wr_data[PVR_CS_INT_INV_BIT];
                    jabber_ff <= wr_data[PVR_CS_JABBER_BIT];
                    sqe_ff <= wr_data[PVR_CS_SQE_BIT];
                end
                default:
                    ;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // self-clearing status bits, a set beats a read clear
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            soft_rst_ff <= 1'b0;
            link_fail_ff <= 1'b0;
        end
        else
        begin
            if (wr_req && reg_addr == PVR_IDX_CTRL_STAT && wr_data[PVR_CS_SOFT_RST_BIT])
                soft_rst_ff <= 1'b1;
            else if (rd_req && reg_addr == PVR_IDX_CTRL_STAT)
                soft_rst_ff <= 1'b0;
            if (link_check_fail)
                link_fail_ff <= 1'b1;
            else if (rd_req && reg_addr == PVR_IDX_CTRL_STAT)
                link_fail_ff <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // extended register portal
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mmd_func_ff <= PVR_MMD_ADDR;
            mmd_dev_ff <= 5'h00;
            mmd_addr_ff <= 16'h0000;
        end
        else
        begin
            if (wr_req && reg_addr == PVR_IDX_MMD_CTRL)
            begin
                mmd_func_ff <= pvr_mmd_func_e'(wr_data[PVR_MC_FUNC_HI:PVR_MC_FUNC_LO]);
                mmd_dev_ff <= wr_data[4:0];
            end
            if (wr_hit_data && mmd_func_ff == PVR_MMD_ADDR)
                mmd_addr_ff <= wr_data;
            else if (mmd_inc)
                mmd_addr_ff <= mmd_addr_ff + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < EXT_WORDS; i++)
                ext_mem[i] <= 16'h0000;
        end
        else if (wr_hit_data && mmd_func_ff != PVR_MMD_ADDR)
            ext_mem[ext_index(mmd_dev_ff, mmd_addr_ff)] <= wr_data;
    end

    // -------------------------------------------------------------------------
    // read data
    // -------------------------------------------------------------------------
    always_comb
    begin
        nxt_rd_data = 16'h0000;
        case (reg_addr)
            PVR_IDX_MMD_CTRL:
                nxt_rd_data = {mmd_func_ff, 9'h000, mmd_dev_ff};
            PVR_IDX_MMD_DATA:
                if (mmd_func_ff == PVR_MMD_ADDR)
                    nxt_rd_data = mmd_addr_ff;
                else
                    nxt_rd_data = ext_mem[ext_index(mmd_dev_ff, mmd_addr_ff)];
            PVR_IDX_XOVER:
            begin
                nxt_rd_data[PVR_XO_PINOUT_BIT] = pinout_ff;
                nxt_rd_data[PVR_XO_AUTO_OFF_BIT] = auto_off_ff;
            end
            PVR_IDX_PWRDN:
            begin
                nxt_rd_data[PVR_PD_CLK_OVR_BIT] = clk_ovr_ff;
                nxt_rd_data[PVR_PD_PLL_OFF_BIT] = pll_off_ff;
                nxt_rd_data[PVR_PD_DC_TEST_BIT] = dc_test_ff;
                nxt_rd_data[PVR_PD_TEST_LVL_BIT] = test_lvl_ff;
            end
            PVR_IDX_LOOPBACK:
                nxt_rd_data[PVR_LB_EXT_BIT] = ext_lb_ff;
            PVR_IDX_CTRL_STAT:
            begin
                nxt_rd_data[PVR_CS_INT_INV_BIT] = int_inv_ff;
                nxt_rd_data[PVR_CS_JABBER_BIT] = jabber_ff;
                nxt_rd_data[PVR_CS_SQE_BIT] = sqe_ff;
                nxt_rd_data[PVR_CS_SPD1000_BIT] = link_speed_1000;
                nxt_rd_data[PVR_CS_SPD100_BIT] = link_speed_100;
                nxt_rd_data[PVR_CS_SPD10_BIT] = link_speed_10;
                nxt_rd_data[PVR_CS_DUPLEX_BIT] = link_full_duplex;
                nxt_rd_data[PVR_CS_MASTER_BIT] = link_master;
                nxt_rd_data[PVR_CS_SOFT_RST_BIT] = soft_rst_ff;
                nxt_rd_data[PVR_CS_LINK_FAIL_BIT] = link_fail_ff | link_check_fail;
            end
            default:
                nxt_rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 16'h0000;
        end
        else
        begin
            rd_valid_ff <= rd_req;
            if (rd_req)
                rd_data_ff <= nxt_rd_data;
        end
    end

    // -------------------------------------------------------------------------
    // outputs to the phy
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            forced_pinout_select <= 1'b0;
            auto_crossover_off <= PVR_RST_AUTO_OFF;
            spd_clock_gate_override <= 1'b0;
            spd_pll_disable <= 1'b0;
            pin_dc_test_enable <= 1'b0;
            pin_test_level <= 1'b0;
            ext_loopback_enable <= 1'b0;
            int_polarity_invert <= 1'b0;
            jabber_enable <= PVR_RST_JABBER_EN;
            sqe_test_enable <= PVR_RST_SQE_EN;
            phy_soft_reset <= 1'b0;
        end
        else
        begin
            forced_pinout_select <= pinout_ff;
            auto_crossover_off <= auto_off_ff;
            spd_clock_gate_override <= clk_ovr_ff;
            spd_pll_disable <= pll_off_ff;
            pin_dc_test_enable <= dc_test_ff;
            pin_test_level <= test_lvl_ff;
            ext_loopback_enable <= ext_lb_ff;
            int_polarity_invert <= int_inv_ff;
            jabber_enable <= jabber_ff;
            sqe_test_enable <= sqe_ff;
            phy_soft_reset <= soft_rst_ff;
        end
    end

endmodule

/* tb/pvr_regs_properties.sv */
`timescale 1ns/100ps
module pvr_regs_properties
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // observed pins
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic auto_crossover_off,
    input wire logic spd_pll_disable,
    input wire logic jabber_enable,
    input wire logic phy_soft_reset
);
    logic [7:0] since_oe_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // cycles since the device last drove the data line
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n)
            since_oe_ff <= 8'hff;
        else if (mdio_oe)
            since_oe_ff <= 8'h00;
        else if (since_oe_ff != 8'hff)
            since_oe_ff <= since_oe_ff + 8'h01;

    a_reset_vals:
        assert property ($rose(reset_n) |-> jabber_enable && !auto_crossover_off)
        else $error("bad value after reset");
    a_oe_rise_low:
        assert property ($rose(mdio_oe) |-> !mdc && !mdio_out)
        else $error("turnaround not driven low");
    a_oe_hold:
        assert property ($rose(mdio_oe) |=> mdio_oe [*3])
        else $error("read drive too short");
    a_oe_drop_hi:
        assert property ($fell(mdio_oe) |-> mdc)
        else $error("drive released off rising edge");
    a_out_stable:
        assert property (mdio_oe && $past(mdio_oe) && mdc && $past(mdc) |-> $stable(mdio_out))
        else $error("read data moved while clock high");
    a_pins_quiet:
        assert property (mdio_oe && $past(mdio_oe)
            |-> $stable({auto_crossover_off, spd_pll_disable, jabber_enable}))
        else $error("control changed during read");
    a_srst_read:
        assert property ($fell(phy_soft_reset) |-> (since_oe_ff < 8'd40) or ##[0:40] mdio_oe)
        else $error("soft reset cleared outside read");
    a_srst_write:
        assert property ($rose(phy_soft_reset) |-> since_oe_ff > 8'd20)
        else $error("soft reset set during read");

    c_read: cover property ($rose(mdio_oe));
    c_srst: cover property ($rose(phy_soft_reset));
    c_auto_off: cover property ($rose(auto_crossover_off));
endmodule

bind pvr_phy_vendor_regs pvr_regs_properties u_pvr_regs_properties (.ref_clk, .reset_n,
    .mdc, .mdio_out, .mdio_oe, .auto_crossover_off, .spd_pll_disable, .jabber_enable,
    .phy_soft_reset);

/* tb/pvr_smi_ctrl.sv */
`timescale 1ns/100ps
module pvr_smi_ctrl
(
    // clock
    input wire logic ref_clk,
    // management pins
    output logic mdc,
    output logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe
);
    logic drv;
    logic drv_en;

    // pull-up holds the line high when nobody drives
    assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);

    initial
    begin
        mdc = 1'b0;
        drv = 1'b0;
        drv_en = 1'b0;
    end

    task automatic clk_bit(input logic b, output logic s);
        @(negedge ref_clk);
        mdc = 1'b0;
        drv = b;
        repeat (2) @(negedge ref_clk);
        s = mdio_in;
        mdc = 1'b1;
        @(negedge ref_clk);
    endtask

    // one management frame, the clock stands low afterwards
    task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] rv);
        logic [63:0] f;
        logic s;
        f = {32'hffff_ffff, 2'b01, rd ? 2'b10 : 2'b01, 5'h01, ra, 2'b10, wd};
        // let an edge pass so the line is not released and retaken in one step
        @(negedge ref_clk);
        drv = 1'b1;
        drv_en = 1'b1;
        for (int i = 63; i >= 0; i--)
        begin
            if (rd && i == 17)
                drv_en = 1'b0;
            clk_bit(f[i], s);
            rv = {rv[14:0], s};
        end
        repeat (3) @(negedge ref_clk);
        mdc = 1'b0;
        drv_en = 1'b0;
    endtask
endmodule

/* tb/pvr_phy_vendor_regs_tb_top.sv */
`timescale 1ns/100ps
module pvr_phy_vendor_regs_tb_top import pvr_pkg::*;;
    logic ref_clk, reset_n, mdc, mdio_in, mdio_out, mdio_oe;
    logic [5:0] lk;
    logic [10:0] pins;
    logic [15:0] q[$];
    logic [15:0] res, rv, xo, pd, lb, cs;
    logic [15:0] mm[3];
    logic [31:0] seed;
    int n_fail, compares;
    event got;

    pvr_phy_vendor_regs u_pvr_phy_vendor_regs (.ref_clk(ref_clk), .reset_n(reset_n),
        .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .link_speed_1000(lk[4]), .link_speed_100(lk[3]), .link_speed_10(lk[2]),
        .link_full_duplex(lk[1]), .link_master(lk[0]), .link_check_fail(lk[5]),
        .forced_pinout_select(pins[10]), .auto_crossover_off(pins[9]),
        .spd_clock_gate_override(pins[8]), .spd_pll_disable(pins[7]),
        .pin_dc_test_enable(pins[6]), .pin_test_level(pins[5]),
        .ext_loopback_enable(pins[4]), .int_polarity_invert(pins[3]),
        .jabber_enable(pins[2]), .sqe_test_enable(pins[1]), .phy_soft_reset(pins[0]));
    pvr_smi_ctrl u_pvr_smi_ctrl (.ref_clk(ref_clk), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [15:0] sts();
        return {9'h000, lk[4:0], 2'b00};
    endfunction

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        u_pvr_smi_ctrl.frame(1'b0, ra, d, rv);
    endtask

    task automatic rd(input logic [4:0] ra, input logic [15:0] e);
        q.push_back(e);
        u_pvr_smi_ctrl.frame(1'b1, ra, 16'h0000, rv);
        res = rv;
        -> got;
    endtask

    task automatic pin_chk(input logic sr);
        q.push_back({5'h00, xo[7:6], pd[11:10], pd[7:6], lb[3], cs[14], cs[9:8], sr});
        @(negedge ref_clk);
        res = {5'h00, pins};
        -> got;
    endtask

    task automatic summarize();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(got)
    begin
        compares++;
        if (q.size() == 0)
        begin
            n_fail++;
            $display("MISMATCH t=%0t no expected value", $time);
        end
        else if (res !== q.pop_front())
        begin
            n_fail++;
            $display("MISMATCH t=%0t got %h", $time, res);
        end
    end

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        summarize();
    end

    initial
    begin
        reset_n = 1'b0;
        lk = 6'h00;
        seed = 32'hc9958a11;
        {xo, pd, lb, cs} = {48'h0, 16'h0300};
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        pin_chk(1'b0);
        rd(PVR_IDX_CTRL_STAT, cs);
        $display("reset test done");
        for (int i = 0; i < 5; i++)
        begin
            seed = xs(seed);
            lk = {1'b0, seed[20:16]};
            {xo, pd, lb} = {seed[15:0] & 16'h00c0, seed[31:16] & 16'h0cc0, seed[15:0] & 16'h0008};
            cs = seed[31:16] & 16'h4300;
            wr(PVR_IDX_XOVER, seed[15:0]);
            wr(PVR_IDX_PWRDN, seed[31:16]);
            wr(PVR_IDX_LOOPBACK, seed[15:0]);
            wr(PVR_IDX_CTRL_STAT, cs);
            pin_chk(1'b0);
            rd(PVR_IDX_XOVER, xo);
            rd(PVR_IDX_PWRDN, pd);
            rd(PVR_IDX_LOOPBACK, lb);
            rd(PVR_IDX_CTRL_STAT, cs | sts());
            $display("register pass %0d done", i);
        end
        wr(PVR_IDX_CTRL_STAT, cs | 16'h0002);
        pin_chk(1'b1);
        rd(PVR_IDX_CTRL_STAT, cs | sts() | 16'h0002);
        pin_chk(1'b0);
        @(negedge ref_clk) lk[5] = 1'b1;
        @(negedge ref_clk) lk[5] = 1'b0;
        rd(PVR_IDX_CTRL_STAT, cs | sts() | 16'h0001);
        rd(PVR_IDX_CTRL_STAT, cs | sts());
        rd(5'h10, 16'h0000);
        $display("status test done");
        wr(PVR_IDX_MMD_CTRL, 16'h0002);
        wr(PVR_IDX_MMD_DATA, 16'h0011);
        wr(PVR_IDX_MMD_CTRL, 16'hc002);
        for (int i = 0; i < 3; i++)
        begin
            seed = xs(seed);
            mm[i] = seed[15:0];
            wr(PVR_IDX_MMD_DATA, mm[i]);
        end
        rd(PVR_IDX_MMD_CTRL, 16'hc002);
        wr(PVR_IDX_MMD_CTRL, 16'h0002);
        wr(PVR_IDX_MMD_DATA, 16'h0012);
        wr(PVR_IDX_MMD_CTRL, 16'h4002);
        rd(PVR_IDX_MMD_DATA, mm[1]);
        rd(PVR_IDX_MMD_DATA, mm[1]);
        wr(PVR_IDX_MMD_DATA, mm[0]);
        wr(PVR_IDX_MMD_CTRL, 16'h0002);
        wr(PVR_IDX_MMD_DATA, 16'h0011);
        wr(PVR_IDX_MMD_CTRL, 16'h8002);
        rd(PVR_IDX_MMD_DATA, mm[0]);
        rd(PVR_IDX_MMD_DATA, mm[0]);
        rd(PVR_IDX_MMD_DATA, mm[2]);
        wr(PVR_IDX_MMD_CTRL, 16'h0002);
        rd(PVR_IDX_MMD_DATA, 16'h0014);
        wr(PVR_IDX_MMD_CTRL, 16'h8002);
        wr(PVR_IDX_MMD_DATA, mm[2]);
        wr(PVR_IDX_MMD_CTRL, 16'h0002);
        rd(PVR_IDX_MMD_DATA, 16'h0015);
        wr(PVR_IDX_MMD_DATA, 16'h0014);
        wr(PVR_IDX_MMD_CTRL, 16'hc002);
        rd(PVR_IDX_MMD_DATA, mm[2]);
        wr(PVR_IDX_MMD_CTRL, 16'h0002);
        rd(PVR_IDX_MMD_DATA, 16'h0014);
        $display("portal test done");
        summarize();
    end
endmodule
